// File: logic/eac_array.sv
// Purpose: byte array of the data nonvolatile memory
// Assumes: one commit pulse per finished programming operation
// Notes:   no reset; contents survive every reset like the real cells
`timescale 1ns/1ps
`default_nettype none
module eac_array #(
  parameter int unsigned DEPTH = eac_pkg::DEPTH_DEF
) (
  input  wire logic                      clk_sys,  // core clock
  input  wire logic                      commit,   // apply operation this cycle
  input  wire logic [1:0]                mode,     // operation to apply
  input  wire logic [$clog2(DEPTH)-1:0]  addr,     // byte index
  input  wire logic [7:0]                wdata,    // byte to program
  output logic      [7:0]                rdata     // byte at addr, combinational
);
  logic [7:0] cells [DEPTH];

  // write-only can only clear bits, so an unerased target keeps junk
  always_ff @(posedge clk_sys) begin
    if (commit) begin
      case (mode)
        eac_pkg::EAC_MODE_ATOMIC: cells[addr] <= wdata;
        eac_pkg::EAC_MODE_ERASE:  cells[addr] <= eac_pkg::ERASED_BYTE;
        eac_pkg::EAC_MODE_WRITE:  cells[addr] <= cells[addr] & wdata;
        default:                  cells[addr] <= cells[addr];
      endcase
    end
  end

  assign rdata = cells[addr];
endmodule
`default_nettype wire

// File: logic/eac_ctrl.sv
// Purpose: cpu-side access controller for the data nonvolatile array
// Assumes: i/o accesses are single-cycle strobes synchronous to clk_sys
// Notes:   rst_n is system reset; only pwr_on_n clears the programming timer
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RL1: array addressed linearly by byte, top address is depth minus one
// RL2: software loads the address pair before any access; it powers up undefined (the code clears it to zero on reset when not busy)
// RL3: unused high-address bits and top two control bits read zero
// RL4: data register feeds programming and holds the byte after a read strobe
// RL5: mode 00 atomic 3.4 ms, 01 erase 1.8 ms, 10 write 1.8 ms, 11 reserved
// RL6: mode writes ignored while program enable is set
// RL7: reset clears mode to 00 unless programming is in progress
// RL8: level ready interrupt when enable and global enable set and array ready
// RL9: master enable self-clears four cycles after software sets it
// RL10: program enable starts operation only within master window, else no effect
// RL11: program enable stays set while busy, clears when access time elapses
// RL12: cpu stalled two cycles after program enable is set
// RL13: read strobe loads data at once, then cpu stalled four cycles
// RL14: no array read and no address change while programming
// RL15: software polls program enable low before issuing a read strobe
// RL16: no other array operation starts while programming is busy
// RL17: reset does not abort a programming operation in progress
// RL18: ready condition is the inverse of the program enable busy bit
module eac_ctrl #(
  parameter int unsigned DEPTH      = eac_pkg::DEPTH_DEF,
  parameter int unsigned ATOMIC_CYC = eac_pkg::ATOMIC_CYC,
  parameter int unsigned SPLIT_CYC  = eac_pkg::SPLIT_CYC
) (
  input  wire logic       clk_sys,    // core clock, 40 MHz
  input  wire logic       rst_n,      // system reset, sync, active low
  input  wire logic       pwr_on_n,   // power-on reset, sync, active low
  input  wire logic [5:0] io_addr,    // i/o register offset
  input  wire logic       io_wr,      // write strobe, one cycle
  input  wire logic       io_rd,      // read strobe, one cycle
  input  wire logic [7:0] io_wdata,   // write data
  input  wire logic       glob_ie,    // global interrupt enable from status register
  output logic      [7:0] io_rdata,   // read data, valid cycle after io_rd
  output logic            cpu_stall,  // halts the core
  output logic            ready_irq   // level interrupt request
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [eac_pkg::ADDR_W-1:0] addr;
  logic [7:0]                 data;
  logic [1:0]                 mode;
  logic                       rie;
  logic                       mpe;
  logic [2:0]                 mpe_cnt;
  logic                       busy;
  logic [eac_pkg::PROG_W-1:0] prog_cnt;
  logic [7:0]                 op_data;
  logic [2:0]                 stall_cnt;
  logic [7:0]                 arr_rdata;
  logic                       commit;
  logic                       wr_ctrl;
  logic                       start_go;
  logic                       rd_go;
  logic [7:0]                 next_rdata;

  // ****************************************************************
  // request decode
  // ****************************************************************
  assign wr_ctrl  = io_wr && (io_addr == eac_pkg::OFF_CONTROL);
  // reserved mode starts nothing rather than guessing a timing
  assign start_go = rst_n && wr_ctrl && io_wdata[eac_pkg::BIT_PE] && mpe && !busy
                    && (mode != eac_pkg::EAC_MODE_RSVD); // RL10 RL16
  assign rd_go    = rst_n && wr_ctrl && io_wdata[eac_pkg::BIT_READ] && !busy; // RL14 RL16
  assign commit   = busy && (prog_cnt == eac_pkg::PROG_W'(1));

  function automatic logic [eac_pkg::PROG_W-1:0] op_time(input logic [1:0] m);
    op_time = (m == eac_pkg::EAC_MODE_ATOMIC) ? eac_pkg::PROG_W'(ATOMIC_CYC)
                                               : eac_pkg::PROG_W'(SPLIT_CYC); // RL5
  endfunction

  // ****************************************************************
  // address and data registers
  // ****************************************************************
  // address frozen during programming so the commit hits the started byte
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      if (!busy) addr <= '0;
    end else if (io_wr && !busy) begin // RL14
      if (io_addr == eac_pkg::OFF_ADDR_LOW) addr[7:0] <= io_wdata;
      if (io_addr == eac_pkg::OFF_ADDR_HIGH) addr[8] <= io_wdata[0];
    end
  end

  // read strobe wins over a same-cycle data write, which cannot happen anyway
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      data <= '0;
    end else if (rd_go) begin
      data <= arr_rdata; // RL4 RL13
    end else if (io_wr && io_addr == eac_pkg::OFF_DATA) begin
      data <= io_wdata; // RL4
    end
  end

  // ****************************************************************
  // control register bits
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      if (!busy) mode <= eac_pkg::EAC_MODE_ATOMIC; // RL7 RL17
      rie <= 1'b0;
    end else if (wr_ctrl) begin
      // the starting write keeps the old mode, so timer and commit agree
      if (!busy && !start_go) mode <= io_wdata[eac_pkg::BIT_MODE_HI:eac_pkg::BIT_MODE_LO]; // RL6
      rie <= io_wdata[eac_pkg::BIT_RIE];
    end
  end

  // master enable window; a fresh write of one does not extend it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mpe     <= 1'b0;
      mpe_cnt <= '0;
    end else if (wr_ctrl && !io_wdata[eac_pkg::BIT_MPE]) begin
      mpe     <= 1'b0;
      mpe_cnt <= '0;
    end else if (wr_ctrl && !mpe) begin
      mpe     <= 1'b1;
      mpe_cnt <= eac_pkg::MPE_WINDOW - 3'h1;
    end else if (mpe) begin
      if (mpe_cnt == 3'h0) mpe <= 1'b0; // RL9
      else mpe_cnt <= mpe_cnt - 3'h1;
    end
  end

  // ****************************************************************
  // programming timer
  // ****************************************************************
  // only power-on clears it, so a system reset lets the operation finish
  always_ff @(posedge clk_sys) begin
    if (!pwr_on_n) begin
      busy     <= 1'b0;
      prog_cnt <= '0;
      op_data  <= '0;
    end else if (start_go) begin
      busy     <= 1'b1; // RL11
      prog_cnt <= op_time(mode); // RL5
      op_data  <= data;
    end else if (busy) begin
      prog_cnt <= prog_cnt - eac_pkg::PROG_W'(1);
      if (commit) busy <= 1'b0; // RL11 RL17
    end
  end

  eac_array #(
    .DEPTH (DEPTH)
  ) u_array (
    .clk_sys (clk_sys),
    .commit  (commit),
    .mode    (mode),
    .addr    (addr[AW-1:0]), // RL1
    .wdata   (op_data),
    .rdata   (arr_rdata)
  );

  // ****************************************************************
  // cpu stall, read-back and interrupt
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stall_cnt <= '0;
      cpu_stall <= 1'b0;
    end else if (start_go) begin
      stall_cnt <= eac_pkg::PROG_STALL - 3'h1; // RL12
      cpu_stall <= 1'b1;
    end else if (rd_go) begin
      stall_cnt <= eac_pkg::READ_STALL - 3'h1; // RL13
      cpu_stall <= 1'b1;
    end else if (stall_cnt != 3'h0) begin
      stall_cnt <= stall_cnt - 3'h1;
    end else begin
      cpu_stall <= 1'b0;
    end
  end

  // read strobe bit always reads zero; unmapped offsets read zero
  always_comb begin
    next_rdata = 8'h00;
    case (io_addr)
      eac_pkg::OFF_ADDR_HIGH: next_rdata = {7'h00, addr[8]}; // RL3
      eac_pkg::OFF_ADDR_LOW:  next_rdata = addr[7:0];
      eac_pkg::OFF_DATA:      next_rdata = data;
      eac_pkg::OFF_CONTROL:   next_rdata = {2'h0, mode, rie, mpe, busy, 1'b0}; // RL3
      default:                next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) io_rdata <= 8'h00;
    else if (io_rd) io_rdata <= next_rdata;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) ready_irq <= 1'b0;
    else ready_irq <= rie && glob_ie && !busy; // RL8 RL18
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_mpe_self_clear: assert property ($rose(mpe) |-> ##[1:4] !mpe) // RL9
    else $error("master enable not cleared within four cycles");
  chk_mode_hold: assert property (busy && $past(busy) |-> $stable(mode)) // RL6
    else $error("mode changed while programming");
  chk_addr_hold: assert property (busy && $past(busy) |-> $stable(addr)) // RL14
    else $error("address changed while programming");
  chk_start_needs_mpe: assert property ($rose(busy) |-> $past(mpe)) // RL10
    else $error("programming started without master enable");
  chk_busy_op_time: assert property ($rose(busy) |-> prog_cnt == op_time(mode)) // RL5
    else $error("programming time does not match mode");
  chk_prog_stall: assert property ($rose(busy) |-> cpu_stall[*2] ##1 !cpu_stall) // RL12
    else $error("program start stall is not two cycles");
  chk_read_stall: assert property (rd_go |=> cpu_stall[*4] ##1 !cpu_stall) // RL13
    else $error("read stall is not four cycles");
  chk_read_data: assert property (rd_go |=> data == $past(arr_rdata)) // RL4
    else $error("read strobe did not load array byte");
  chk_irq_level: assert property (busy |=> !ready_irq) // RL18
    else $error("ready interrupt while busy");
  chk_ctrl_top_zero: assert property (
    io_rd && io_addr == eac_pkg::OFF_CONTROL |=> io_rdata[7:6] == 2'h0) // RL3
    else $error("control top bits not zero");

  cov_atomic_done: cover property ($fell(busy) && mode == eac_pkg::EAC_MODE_ATOMIC);
  cov_read: cover property (rd_go);
  cov_pe_without_mpe: cover property (wr_ctrl && io_wdata[eac_pkg::BIT_PE] && !mpe);
endmodule
`default_nettype wire

// File: logic/eac_pkg.sv
// Purpose: shared constants for the data nonvolatile access controller
// Assumes: core clock of 40 MHz, byte-wide I/O register port
// Notes:   timing counts are derived from the printed times and the clock rate
package eac_pkg;
  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ        = 40;
  localparam int unsigned T_ATOMIC_US    = 3400;   // erase and write, 3.4 ms
  localparam int unsigned T_SPLIT_US     = 1800;   // erase only or write only, 1.8 ms
  localparam int unsigned ATOMIC_CYC     = T_ATOMIC_US * CLK_MHZ;
  localparam int unsigned SPLIT_CYC      = T_SPLIT_US * CLK_MHZ;
  localparam int unsigned PROG_W         = 18;     // wide enough for the atomic count
  localparam logic [2:0]  MPE_WINDOW     = 3'h4;   // master enable lifetime in cycles
  localparam logic [2:0]  PROG_STALL     = 3'h2;   // cpu halt after program start
  localparam logic [2:0]  READ_STALL     = 3'h4;   // cpu halt after read strobe

  // ****************************************************************
  // array geometry
  // ****************************************************************
  localparam int unsigned DEPTH_DEF      = 512;
  localparam int unsigned ADDR_W         = 9;
  localparam logic [7:0]  ERASED_BYTE    = 8'hff;

  // ****************************************************************
  // i/o register map
  // ****************************************************************
  localparam logic [5:0]  OFF_ADDR_HIGH  = 6'h00;
  localparam logic [5:0]  OFF_ADDR_LOW   = 6'h01;
  localparam logic [5:0]  OFF_DATA       = 6'h02;
  localparam logic [5:0]  OFF_CONTROL    = 6'h03;

  // control register fields
  localparam int unsigned BIT_READ       = 0;
  localparam int unsigned BIT_PE         = 1;
  localparam int unsigned BIT_MPE        = 2;
  localparam int unsigned BIT_RIE        = 3;
  localparam int unsigned BIT_MODE_LO    = 4;
  localparam int unsigned BIT_MODE_HI    = 5;

  typedef enum logic [1:0] {
    EAC_MODE_ATOMIC = 2'h0,
    EAC_MODE_ERASE  = 2'h1,
    EAC_MODE_WRITE  = 2'h2,
    EAC_MODE_RSVD   = 2'h3
  } eac_mode_t;
endpackage

// File: tb/eac_cpu_model.sv
// Purpose: cpu core model issuing i/o accesses to the controller
// Assumes: strobes change at the falling edge only
// Notes:   an idle bus shows inverted values so stale data never matches
`timescale 1ns/1ps
`default_nettype none
module eac_cpu_model (
  input  wire logic       clk_sys,   // core clock
  output logic      [5:0] io_addr,   // register offset
  output logic            io_wr,     // write strobe
  output logic            io_rd,     // read strobe
  output logic      [7:0] io_wdata,  // write data
  input  wire logic [7:0] io_rdata,  // read data
  input  wire logic       cpu_stall  // core halt
);
  int stall_cnt = 0;  // halted cycles after the last access
  // idle bus at time zero
  initial begin
    io_addr  = 6'h3f;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_wdata = 8'h00;
  end
  // the core stays quiet for a fixed window, long enough for any halt
  task automatic settle();
    stall_cnt = 0;
    repeat (8) begin
      if (cpu_stall === 1'b1) stall_cnt++;
      @(negedge clk_sys);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    io_addr  = a;
    io_wdata = d;
    io_wr    = 1'b1;
    @(negedge clk_sys);
    io_wr    = 1'b0;
    io_addr  = ~a;
    io_wdata = ~d;
  endtask
  // data lands on the same edge that takes the strobe
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    io_addr = a;
    io_rd   = 1'b1;
    @(negedge clk_sys);
    io_rd   = 1'b0;
    io_addr = ~a;
    @(negedge clk_sys);
    d = io_rdata;
  endtask
endmodule
`default_nettype wire

// File: tb/tb_eac_ctrl.sv
// Purpose: self-checking bench for the nonvolatile access controller
// Assumes: busy counts shortened to 80 and 40 cycles
// Notes:   the cpu model owns the strobes; the bench drives resets and glob_ie
`timescale 1ns/1ps
`default_nettype none
module tb_eac_ctrl;
  localparam int AC = 80;  // atomic busy cycles
  localparam int SC = 40;  // split busy cycles
  logic            clk_sys = 1'b0;  // core clock
  logic            rst_n;           // system reset
  logic            pwr_on_n;        // power-on reset
  logic            glob_ie;         // global interrupt enable
  wire logic [5:0] io_addr;         // register offset
  wire logic       io_wr;           // write strobe
  wire logic       io_rd;           // read strobe
  wire logic [7:0] io_wdata;        // write data
  wire logic [7:0] io_rdata;        // read data
  wire logic       cpu_stall;       // core halt
  wire logic       ready_irq;       // ready request
  int              failures = 0;    // mismatches
  int              num_checks = 0;  // comparisons
  int              cyc = 0;         // free cycle count
  int              t0 = 0;          // cycle of program start

  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  eac_cpu_model cpu (.clk_sys(clk_sys), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .cpu_stall(cpu_stall));
  eac_ctrl #(.DEPTH(512), .ATOMIC_CYC(AC), .SPLIT_CYC(SC)) DUT (.clk_sys(clk_sys),
    .rst_n(rst_n), .pwr_on_n(pwr_on_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .glob_ie(glob_ie), .io_rdata(io_rdata), .cpu_stall(cpu_stall),
    .ready_irq(ready_irq));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s exp %0h got %0h", nm, exp, got);
    end
  endtask
  task automatic summarize();
    if (failures == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic pulse_rst();
    @(negedge clk_sys);
    rst_n = 1'b0;
    @(negedge clk_sys);
    rst_n = 1'b1;
  endtask
  // the address is always loaded before an access
  task automatic set_addr(input logic [8:0] a);
    cpu.wr(6'h00, {7'h00, a[8]});
    cpu.wr(6'h01, a[7:0]);
  endtask
  task automatic read_byte(input logic [8:0] a, input logic [7:0] exp);
    logic [7:0] v;
    set_addr(a);
    cpu.wr(6'h03, 8'h09);
    cpu.settle();
    chk("read stall", cpu.stall_cnt, 4);
    cpu.rd(6'h02, v);
    chk("read byte", v, exp);
  endtask
  // pe follows mpe at once so it lands inside the window
  task automatic launch(input logic [1:0] m, input logic [8:0] a, input logic [7:0] d);
    set_addr(a);
    cpu.wr(6'h02, d);
    cpu.wr(6'h03, {2'h0, m, 4'hc});
    cpu.wr(6'h03, {2'h0, m, 4'he});
    t0 = cyc;
    cpu.settle();
    chk("prog stall", cpu.stall_cnt, 2);
  endtask
  // polling adds a few cycles, hence the small tolerance
  task automatic wait_idle(input int exp);
    logic [7:0] v;
    v = 8'h02;
    for (int i = 0; i < 300 && v[1] !== 1'b0; i++) begin
      cpu.rd(6'h03, v);
    end
    if (v[1] !== 1'b0) begin
      failures++;
      summarize();
    end
    chk("busy length", cyc - t0 >= exp && cyc - t0 <= exp + 6, 1);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic s_regs();
    logic [7:0] v;
    cpu.rd(6'h03, v);
    chk("ctrl reset", v, 8'h00);
    cpu.wr(6'h00, 8'hff);
    cpu.rd(6'h00, v);
    chk("addr high", v, 8'h01);
    cpu.wr(6'h03, 8'hc8);
    cpu.rd(6'h03, v);
    chk("ctrl top", v, 8'h08);
    cpu.rd(6'h10, v);
    chk("unmapped", v, 8'h00);
    glob_ie = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("irq on", ready_irq, 1'b1);
    glob_ie = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("irq masked", ready_irq, 1'b0);
    glob_ie = 1'b1;
  endtask
  task automatic s_window();
    logic [7:0] v;
    cpu.wr(6'h03, 8'h0c);
    cpu.rd(6'h03, v);
    chk("mpe set", v, 8'h0c);
    repeat (3) @(negedge clk_sys);
    cpu.rd(6'h03, v);
    chk("mpe gone", v, 8'h08);
    cpu.wr(6'h03, 8'h0a);
    cpu.rd(6'h03, v);
    chk("late pe", v, 8'h08);
    cpu.wr(6'h03, 8'h3c);
    cpu.wr(6'h03, 8'h3e);
    cpu.rd(6'h03, v);
    chk("mode 11", v[1], 1'b0);
    cpu.wr(6'h03, 8'h08);
  endtask
  task automatic s_atomic();
    logic [7:0] v;
    launch(2'h0, 9'h1ff, 8'h5a);
    chk("irq busy", ready_irq, 1'b0);
    cpu.rd(6'h03, v);
    chk("busy bit", v, 8'h0a);
    cpu.wr(6'h03, 8'h1a);
    set_addr(9'h005);
    cpu.wr(6'h03, 8'h0b);
    cpu.settle();
    chk("no rd stall", cpu.stall_cnt, 0);
    // restart attempt carries mode 01, so a leaked mode write shows up
    cpu.wr(6'h03, 8'h1c);
    cpu.wr(6'h03, 8'h1e);
    cpu.rd(6'h03, v);
    chk("mode kept", v[5:4], 2'h0);
    cpu.rd(6'h01, v);
    chk("addr kept", v, 8'hff);
    cpu.rd(6'h02, v);
    chk("data kept", v, 8'h5a);
    wait_idle(AC);
    cpu.rd(6'h03, v);
    chk("no restart", v[1], 1'b0);
    chk("irq ready", ready_irq, 1'b1);
    read_byte(9'h1ff, 8'h5a);
  endtask
  task automatic s_split();
    launch(2'h1, 9'h000, 8'h00);
    wait_idle(SC);
    read_byte(9'h000, 8'hff);
    launch(2'h2, 9'h000, 8'h3c);
    wait_idle(SC);
    read_byte(9'h000, 8'h3c);
  endtask
  task automatic s_reset();
    logic [7:0] v;
    launch(2'h2, 9'h1ff, 8'h0f);
    pulse_rst();
    cpu.rd(6'h03, v);
    chk("busy kept", v, 8'h22);
    wait_idle(SC);
    read_byte(9'h1ff, 8'h0a);
    cpu.wr(6'h03, 8'h10);
    pulse_rst();
    cpu.rd(6'h03, v);
    chk("mode cleared", v, 8'h00);
  endtask

  initial begin
    rst_n    = 1'b0;
    pwr_on_n = 1'b0;
    glob_ie  = 1'b0;
    repeat (4) @(negedge clk_sys);
    rst_n    = 1'b1;
    pwr_on_n = 1'b1;
    s_regs();
    s_window();
    s_atomic();
    s_split();
    s_reset();
    summarize();
  end
endmodule
`default_nettype wire
